// >>> companion_model.sv
// Linked control module that follows the mapped run function.
`timescale 1ns/100ps
`default_nettype none
module companion_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire contact_map_pkg::function_out_t function_out,
  output logic linked_run_ff
);
  // Selection bit set to one, so this module follows the input module.
  localparam logic LINK_SEL = 1'b1;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) linked_run_ff <= 1'b0;
    else if (LINK_SEL) linked_run_ff <= function_out.run_valid &
      function_out.run_request;
  end
endmodule : companion_model
`default_nettype wire

// >>> contact_filter.sv
// Hold-time qualifier for one contact input, with rising-edge pulse.
`timescale 1ns/100ps
`default_nettype none
module contact_filter (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic raw,
  output logic level,
  output logic rise
);
  // Wide enough for the full hold count; a narrower counter would wrap.
  logic [24:0] count_ff;
  logic level_ff;
  logic prev_ff;

  // A change is accepted only after holding longer than the hold time.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 25'h0000000;
      level_ff <= 1'b0;
    end else if (raw == level_ff) begin
      count_ff <= 25'h0000000;
    end else if (count_ff >= 25'(contact_map_pkg::HOLD_CYCLES - 1)) begin
      count_ff <= 25'h0000000;
      level_ff <= raw; // R11
    end else begin
      count_ff <= count_ff + 25'h0000001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level_ff;
    end
  end

  assign level = level_ff;
  assign rise = level_ff & ~prev_ff; // R10
endmodule : contact_filter
`default_nettype wire

// >>> contact_input_function_map.sv
// Maps eight qualified contact inputs to control functions by code.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (R1) Configuration writes accepted only while stopped.
// (R2) While running, configuration is read-only.
// (R3) Code 0..29 selects one input mapping.
// (R4) Code resets to zero: no functions.
// (R5) Code 26 full mapping, mode on 7-8.
// (R6) Code 28 like 26, suppress starts 7-8.
// (R7) Linked functions switched by contact state.
// (R8) Companion module selects this module to link.
// (R9) Switched functions apply unit-wide.
// (R10) Pulse functions fire on rising edge.
// (R11) Contact valid after closed over 250 ms.
// (R12) Stop from either source wins.
// (R13) Unassigned inputs affect nothing.
// (R14) Out-of-range code writes are rejected.
module contact_input_function_map (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] contact_input,
  input wire contact_map_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic code_writable,
  output logic run_active,
  output contact_map_pkg::function_out_t function_out
);
  logic [15:0] function_code_ff;
  logic [15:0] run_halt_ff;
  logic [7:0] lvl;
  logic [7:0] rise;
  logic run_contact_stop;
  logic [4:0] code;
  contact_map_pkg::function_out_t nxt_func;
  contact_map_pkg::function_out_t func_ff;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_filter
      contact_filter u_filter (
        .mclk(mclk),
        .rst_n(rst_n),
        .raw(contact_input[gi]),
        .level(lvl[gi]),
        .rise(rise[gi])
      );
    end
  endgenerate

  assign code = function_code_ff[4:0];
  assign code_writable = (run_halt_ff == contact_map_pkg::RUN_HALT_STOP); // R1

  // The communicated run/stop setting is a plain register with no gating.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_halt_ff <= contact_map_pkg::RUN_HALT_STOP;
    end else if (reg_req.write &&
                 reg_req.addr == contact_map_pkg::RUN_HALT_ADDR) begin
      run_halt_ff <= reg_req.wdata;
    end
  end

  // Writes while running, or out of range, leave the code untouched.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      function_code_ff <= contact_map_pkg::FUNCTION_CODE_RESET; // R4
    end else if (reg_req.write &&
                 reg_req.addr == contact_map_pkg::FUNCTION_CODE_ADDR &&
                 code_writable && // R2
                 reg_req.wdata <= contact_map_pkg::FUNCTION_CODE_MAX) begin
      function_code_ff <= reg_req.wdata; // R3 R14
    end
  end

  always_comb begin
    unique case (reg_req.addr)
      contact_map_pkg::FUNCTION_CODE_ADDR: reg_rdata = function_code_ff;
      contact_map_pkg::RUN_HALT_ADDR: reg_rdata = run_halt_ff;
      default: reg_rdata = 16'h0000;
    endcase
  end

  // Only the codes with a fully specified table entry assign functions;
  // everything else leaves every output invalid and pulses low.
  always_comb begin
    nxt_func = '0; // R13
    run_contact_stop = 1'b0;
    unique case (code)
      contact_map_pkg::CODE_FULL, contact_map_pkg::CODE_DUAL_EDS: begin
        nxt_func.memory_area = {2'b00, lvl[0]}; // R5
        nxt_func.memory_area_valid = 1'b1;
        nxt_func.area_set = rise[1];
        nxt_func.interlock_release = rise[2]; // R10
        run_contact_stop = ~lvl[3];
        nxt_func.run_valid = 1'b1;
        nxt_func.manual_mode = lvl[4];
        nxt_func.manual_valid = 1'b1;
        nxt_func.remote_mode = lvl[5];
        nxt_func.remote_valid = 1'b1;
        if (code == contact_map_pkg::CODE_FULL) begin
          nxt_func.operation_mode = {lvl[7], lvl[6]};
          nxt_func.operation_mode_valid = 1'b1;
        end else begin
          nxt_func.disturbance_suppress_start_1 = rise[6]; // R6
          nxt_func.disturbance_suppress_start_2 = rise[7]; // R6
        end
      end
      contact_map_pkg::CODE_AREA8_MODE: begin
        nxt_func.memory_area = {lvl[2], lvl[1], lvl[0]};
        nxt_func.memory_area_valid = 1'b1;
        nxt_func.area_set = rise[3];
        nxt_func.operation_mode = {lvl[5], lvl[4]};
        nxt_func.operation_mode_valid = 1'b1;
      end
      contact_map_pkg::CODE_EDS_MODE: begin
        nxt_func.disturbance_suppress_start_1 = rise[0];
        nxt_func.disturbance_suppress_start_2 = rise[1];
        nxt_func.operation_mode = {lvl[7], lvl[6]};
        nxt_func.operation_mode_valid = 1'b1;
      end
      default: begin
      end
    endcase
    // Stop from either the contact or the register always wins.
    nxt_func.run_request = ~run_contact_stop & ~code_writable; // R12
  end

  // Registered outputs go to every linked module of the unit alike.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      func_ff <= '0;
    end else begin
      func_ff <= nxt_func; // R7 R9
    end
  end

  assign function_out = func_ff;
  assign run_active = func_ff.run_request;
endmodule : contact_input_function_map
`default_nettype wire

// >>> contact_input_function_map_tb.sv
// Testbench for the contact input function map.
`timescale 1ns/100ps
`default_nettype none
module contact_input_function_map_tb;
  logic mclk = 0;
  logic rst_n = 0;
  logic [7:0] contact_input = 8'h00;
  contact_map_pkg::reg_req_t reg_req = '0;
  logic [15:0] reg_rdata;
  logic code_writable, run_active, linked_run_ff;
  contact_map_pkg::function_out_t function_out;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  contact_input_function_map dut (.mclk, .rst_n, .contact_input, .reg_req,
    .reg_rdata, .code_writable, .run_active, .function_out);
  companion_model partner (.mclk, .rst_n, .function_out, .linked_run_ff);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    #1 reg_req = '{1'b1, a, d};
    @(posedge mclk);
    #1 reg_req.write = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    reg_req.addr = a;
    #1 check(reg_rdata, exp);
  endtask : rd
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // Far above the 83 cycles the sequence needs.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    #1 rst_n = 1;
    rd(16'h00a4, 16'h0000);
    rd(16'h0010, 16'h0000);
    check({15'h0, code_writable}, 16'h0001);
    $display("reset test ends");
    wr(16'h00a4, 16'h001a); rd(16'h00a4, 16'h001a);
    wr(16'h00a4, 16'h001e); rd(16'h00a4, 16'h001a);
    wr(16'h00a4, 16'h001d); rd(16'h00a4, 16'h001d);
    $display("code test ends");
    wr(16'h0046, 16'h0001);
    check({15'h0, code_writable}, 16'h0000);
    wr(16'h00a4, 16'h001c); rd(16'h00a4, 16'h001d);
    repeat (2) @(posedge mclk);
    #1 check({15'h0, run_active}, 16'h0001);
    wr(16'h0046, 16'h0000);
    wr(16'h00a4, 16'h001c); rd(16'h00a4, 16'h001c);
    $display("run test ends");
    contact_input = 8'hff;
    repeat (60) @(posedge mclk);
    #1 contact_input = 8'h00;
    repeat (3) @(posedge mclk);
    #1 check({13'h0, function_out.memory_area}, 16'h0000);
    check({12'h0, function_out.memory_area_valid, function_out.run_valid,
      function_out.manual_mode, function_out.remote_mode}, 16'h000c);
    check({15'h0, linked_run_ff}, 16'h0000);
    $display("glitch test ends");
    report_and_stop();
  end
endmodule : contact_input_function_map_tb
`default_nettype wire

// >>> contact_map_pkg.sv
// Shared constants and types for the contact input function map.
package contact_map_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned HOLD_MS = 250;
  localparam int unsigned HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_MS + 1;
  localparam logic [15:0] FUNCTION_CODE_ADDR = 16'h00a4;
  localparam logic [15:0] RUN_HALT_ADDR = 16'h0046;
  localparam logic [15:0] FUNCTION_CODE_RESET = 16'h0000;
  localparam logic [15:0] FUNCTION_CODE_MAX = 16'h001d;
  localparam logic [15:0] RUN_HALT_STOP = 16'h0000;
  localparam logic [4:0] CODE_FULL = 5'h1a;
  localparam logic [4:0] CODE_DUAL_EDS = 5'h1c;
  localparam logic [4:0] CODE_EDS_MODE = 5'h1d;
  localparam logic [4:0] CODE_AREA8_MODE = 5'h1b;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] memory_area;
    logic memory_area_valid;
    logic area_set;
    logic interlock_release;
    logic run_request;
    logic run_valid;
    logic manual_mode;
    logic manual_valid;
    logic remote_mode;
    logic remote_valid;
    logic [1:0] operation_mode;
    logic operation_mode_valid;
    logic disturbance_suppress_start_1;
    logic disturbance_suppress_start_2;
  } function_out_t;
endpackage : contact_map_pkg

// >>> contact_map_properties.sv
// Checker for the contact input function map ports.
`timescale 1ns/100ps
`default_nettype none
module contact_map_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] contact_input,
  input wire contact_map_pkg::reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic code_writable,
  input wire logic run_active,
  input wire contact_map_pkg::function_out_t function_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wr_code;
  assign wr_code = reg_req.write && reg_req.addr == 16'h00a4;
  stop_writable_a: assert property (reg_req.write && reg_req.addr == 16'h0046
    |=> code_writable == ($past(reg_req.wdata) == 16'h0000))
    else $error("writable flag wrong");
  code_taken_a: assert property (code_writable && wr_code &&
    reg_req.wdata <= 16'h001d ##1 reg_req.addr == 16'h00a4
    |-> reg_rdata == $past(reg_req.wdata)) else $error("code not stored");
  run_locked_a: assert property (!code_writable && wr_code ##1
    reg_req.addr == 16'h00a4 |-> $stable(reg_rdata)) else $error("code changed");
  code_range_a: assert property (reg_req.addr == 16'h00a4
    |-> reg_rdata <= 16'h001d) else $error("code out of range");
  bad_code_a: assert property (wr_code && reg_req.wdata > 16'h001d ##1
    reg_req.addr == 16'h00a4 |-> $stable(reg_rdata)) else $error("bad code kept");
  stop_wins_a: assert property (run_active |-> $past(!code_writable))
    else $error("run while stopped");
  release_pulse_a: assert property (function_out.interlock_release
    |=> !function_out.interlock_release) else $error("pulse too long");
  manual_hold_a: assert property ($rose(function_out.manual_mode) &&
    $past(function_out.manual_valid) |-> $past(contact_input[4], 2) &&
    $past(contact_input[4], 8)) else $error("contact not held");
  cover property (wr_code && code_writable);
  cover property (wr_code && !code_writable);
  cover property (run_active);
endmodule : contact_map_props
bind contact_input_function_map contact_map_props props (.mclk, .rst_n,
  .contact_input, .reg_req, .reg_rdata, .code_writable, .run_active,
  .function_out);
`default_nettype wire
